/* design/sfp_fifo.sv */
`timescale 1ns/1ps
// ==========================================================
// word fifo with valid/ready on both sides
// ==========================================================
module sfp_fifo #(
  parameter int unsigned WIDTH = 21,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned IW = $clog2(DEPTH)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [IW-1:0] wr_idx,
  output logic [IW-1:0] rd_idx,
  output logic [IW:0] level
);
  // all state in one word
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [IW-1:0] wr;
    logic [IW-1:0] rd;
    logic [IW:0] cnt;
  } sfp_fifo_s;

  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
  localparam logic [IW:0] FULL = (IW + 1)'(DEPTH);

  sfp_fifo_s st;
  sfp_fifo_s next_st;
  logic push;
  logic pop;

  // advance an index, wrapping inside the region
  function automatic logic [IW-1:0] step(input logic [IW-1:0] i);
    return (i == LAST) ? '0 : i + 1'b1;
  endfunction

  assign in_ready = st.cnt != FULL;
  assign out_valid = st.cnt != '0;
  assign out_data = st.mem[st.rd];
  assign wr_idx = st.wr;
  assign rd_idx = st.rd;
  assign level = st.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state: store, advance, count
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = step(st.wr); // RQ15
    end
    if (pop) begin
      next_st.rd = step(st.rd); // RQ15
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_full_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    (st.cnt == FULL && !pop) |=> (st.wr == $past(st.wr)) && (st.cnt == FULL))
    else $error("full fifo accepted a word");
  a_idx_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (pop && st.rd == LAST) |=> st.rd == '0)
    else $error("read index did not wrap");
endmodule

/* design/sfp_pkg.sv */
// ==========================================================
// shared constants for the serial fifo pointer/debug block
// ==========================================================
package sfp_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // register byte addresses
  localparam logic [11:0] OFF_CTRL = 12'h114;
  localparam logic [11:0] OFF_PTR = 12'h118;
  localparam logic [11:0] OFF_OUT = 12'h11C;
  localparam logic [11:0] OFF_DBG = 12'h120;
  // 32 transmit entry words, 0x180 .. 0x1FC
  localparam logic [11:0] OFF_TXIN = 12'h180;
  localparam logic [11:0] TXIN_MASK = 12'hF80;
  localparam int unsigned TXIN_IDX_LSB = 2;
  // word and control info layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned RCI_LSB = 16;
  localparam int unsigned RCI_W = 5;
  localparam int unsigned TCI_W = 5;
  localparam int unsigned STAT_W = 5;
  localparam int unsigned LEN_W = 4;
  localparam int unsigned CONTROL_INFO_MODE_SELECT_W = 2;
  localparam logic [1:0] CONTROL_INFO_MODE_SELECT_RST = 2'h0;
  // pointer register field positions
  localparam int unsigned PTR_W = 6;
  localparam int unsigned TW_LSB = 0;
  localparam int unsigned TR_LSB = 8;
  localparam int unsigned RW_LSB = 16;
  localparam int unsigned RR_LSB = 24;
  // buffer and service request sizes
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SRQ_W = 6;
  // control info modes
  localparam logic [1:0] CONTROL_INFO_MODE_SELECT_RAW = 2'h0;
  localparam logic [1:0] CONTROL_INFO_MODE_SELECT_LEN = 2'h1;
  localparam logic [1:0] CONTROL_INFO_MODE_SELECT_LENLO = 2'h2;
  localparam logic [1:0] CONTROL_INFO_MODE_SELECT_FLAGS = 2'h3;
  // bus transfer phases
  typedef enum logic [1:0] {
    SFP_IDLE = 2'b00,
    SFP_ANSWER = 2'b01
  } sfp_phase_e;

  // shape the control info field from stored status and length
  function automatic logic [4:0] rci_format(input logic [1:0] mode,
                                            input logic [4:0] stat,
                                            input logic [3:0] len);
    logic [4:0] r;
    r = stat;
    unique case (mode)
      CONTROL_INFO_MODE_SELECT_RAW: r = stat;
      CONTROL_INFO_MODE_SELECT_LEN: r = {stat[4], len};
      CONTROL_INFO_MODE_SELECT_LENLO: r = {stat[4:3], len[2:0]};
      CONTROL_INFO_MODE_SELECT_FLAGS: r = {len[3], stat[3:0]};
    endcase
    return r;
  endfunction
endpackage

/* design/sfp_top.sv */
`timescale 1ns/1ps
// What this block does
// (RQ1) debug read shows oldest word, no release
// (RQ2) debug bits 20:16 mirror receive control info
// (RQ3) hardware alone moves all four pointers
// (RQ4) pointer register readable, writes ignored
// (RQ5) tx write pointer marks next entry word
// (RQ6) tx read pointer in bits 13:8
// (RQ7) rx write pointer marks next received entry
// (RQ8) rx read pointer in bits 29:24
// (RQ9) debug bits 31:21 read zero
// (RQ10) both channels' six request lines merged
// (RQ11) debug view at 0x120, resets zero
// (RQ12) receive port read releases entry, advances pointer
// (RQ13) writes to debug view ignored
// (RQ14) control info layout follows mode select
// (RQ15) pointers step by one, wrap in region
// (RQ16) pointer reserved bits zero, fields reset zero
module sfp_top #(
  parameter int unsigned DEPTH = sfp_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sfp_pkg::ADDR_W-1:0] paddr,
  input wire logic [sfp_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [sfp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit holding register side
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [sfp_pkg::WORD_W-1:0] tx_data,
  output logic [sfp_pkg::TCI_W-1:0] tx_ctrl,
  // receive holding register side
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [sfp_pkg::WORD_W-1:0] rx_data,
  input wire logic [sfp_pkg::STAT_W-1:0] rx_stat,
  input wire logic [sfp_pkg::LEN_W-1:0] rx_len,
  // per channel service requests
  input wire logic [sfp_pkg::SRQ_W-1:0] ch0_srq,
  input wire logic [sfp_pkg::SRQ_W-1:0] ch1_srq,
  output logic [sfp_pkg::SRQ_W-1:0] service_request_lines
);
  // ==========================================================
  // widths and state
  // ==========================================================
  localparam int unsigned IW = $clog2(DEPTH);
  localparam int unsigned TXW = sfp_pkg::WORD_W + sfp_pkg::TCI_W;
  localparam int unsigned RXW = sfp_pkg::WORD_W + sfp_pkg::STAT_W + sfp_pkg::LEN_W;
  localparam logic [IW:0] FULL = (IW + 1)'(DEPTH);

  // every flop of the top level
  typedef struct packed {
    sfp_pkg::sfp_phase_e phase; // bus phase
    logic pready; // answer strobe
    logic pslverr; // unmapped address
    logic [31:0] prdata; // read answer
    logic [1:0] control_info_mode_select; // control info mode select
    logic tx_valid; // holding stage full
    logic [15:0] tx_data; // holding stage word
    logic [4:0] tx_ctrl; // holding stage control
    logic rx_ready; // room for one more word
    logic [5:0] srq; // merged request lines
  } sfp_top_s;

  sfp_top_s st;
  sfp_top_s next_st;

  // fifo wiring
  logic tx_in_valid;
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_out_ready;
  logic [TXW-1:0] tx_out;
  logic [IW-1:0] tx_wr_idx;
  logic [IW-1:0] tx_rd_idx;
  logic [IW:0] tx_level;
  logic rx_in_valid;
  logic rx_out_valid;
  logic rx_out_ready;
  logic [RXW-1:0] rx_out;
  logic [IW-1:0] rx_wr_idx;
  logic [IW-1:0] rx_rd_idx;
  logic [IW:0] rx_level;

  // bus decode
  logic done; // transfer completes this edge
  logic hit_ctrl;
  logic hit_ptr;
  logic hit_out;
  logic hit_dbg;
  logic hit_txin;
  logic [4:0] txin_tci; // entry number becomes control info
  logic [31:0] view_word; // oldest received word as seen by software
  logic [31:0] ptr_word; // pointer register image
  logic [IW:0] rx_next_level;

  // ==========================================================
  // address decode
  // ==========================================================
  assign hit_ctrl = paddr == sfp_pkg::OFF_CTRL;
  assign hit_ptr = paddr == sfp_pkg::OFF_PTR;
  assign hit_out = paddr == sfp_pkg::OFF_OUT;
  assign hit_dbg = paddr == sfp_pkg::OFF_DBG; // RQ11
  assign hit_txin = (paddr & sfp_pkg::TXIN_MASK) == sfp_pkg::OFF_TXIN;
  assign txin_tci = paddr[sfp_pkg::TXIN_IDX_LSB +: sfp_pkg::TCI_W];
  assign done = psel && penable && st.pready;

  // ==========================================================
  // buffers
  // ==========================================================
  // transmit: entry writes of at least the low byte push a word
  assign tx_in_valid = done && pwrite && hit_txin && pstrb[0];
  // holding stage takes a word whenever it is empty or emptying
  assign tx_out_ready = !st.tx_valid || tx_ready;
  // receive: held off by the registered ready
  assign rx_in_valid = rx_valid && st.rx_ready;
  // only a completed read of the normal port releases an entry
  assign rx_out_ready = done && !pwrite && hit_out; // RQ12

  // transmit fifo, entry writes in, holding register out
  sfp_fifo #(
    .WIDTH(TXW),
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data({txin_tci, pwdata[sfp_pkg::WORD_W-1:0]}),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out),
    .wr_idx(tx_wr_idx),
    .rd_idx(tx_rd_idx),
    .level(tx_level)
  );

  // receive fifo, holding register in, bus reads out
  sfp_fifo #(
    .WIDTH(RXW),
    .DEPTH(DEPTH),
    .IW(IW)
  ) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rx_in_valid),
    .in_ready(),
    .in_data({rx_len, rx_stat, rx_data}),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out),
    .wr_idx(rx_wr_idx),
    .rd_idx(rx_rd_idx),
    .level(rx_level)
  );

  // ==========================================================
  // read images
  // ==========================================================
  // oldest word plus shaped control info, zero when empty
  always_comb begin
    view_word = '0; // RQ9
    if (rx_out_valid) begin
      view_word[sfp_pkg::WORD_W-1:0] = rx_out[sfp_pkg::WORD_W-1:0]; // RQ1
      view_word[sfp_pkg::RCI_LSB +: sfp_pkg::RCI_W] = sfp_pkg::rci_format(st.control_info_mode_select,
        rx_out[sfp_pkg::WORD_W +: sfp_pkg::STAT_W],
        rx_out[sfp_pkg::WORD_W + sfp_pkg::STAT_W +: sfp_pkg::LEN_W]); // RQ2 RQ14
    end
  end

  // pointer image, indices zero extended, gaps zero
  always_comb begin
    ptr_word = '0; // RQ16
    ptr_word[sfp_pkg::TW_LSB +: sfp_pkg::PTR_W] = sfp_pkg::PTR_W'(tx_wr_idx); // RQ5
    ptr_word[sfp_pkg::TR_LSB +: sfp_pkg::PTR_W] = sfp_pkg::PTR_W'(tx_rd_idx); // RQ6
    ptr_word[sfp_pkg::RW_LSB +: sfp_pkg::PTR_W] = sfp_pkg::PTR_W'(rx_wr_idx); // RQ7
    ptr_word[sfp_pkg::RR_LSB +: sfp_pkg::PTR_W] = sfp_pkg::PTR_W'(rx_rd_idx); // RQ8
  end

  // level after this cycle's push and pop
  always_comb begin
    rx_next_level = rx_level;
    if (rx_in_valid && !(rx_out_ready && rx_out_valid)) begin
      rx_next_level = rx_level + 1'b1;
    end else if (!rx_in_valid && rx_out_ready && rx_out_valid) begin
      rx_next_level = rx_level - 1'b1;
    end
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // bus: one wait state, answer in the second access cycle
    unique case (st.phase)
      sfp_pkg::SFP_IDLE: begin
        if (psel && penable) begin
          next_st.phase = sfp_pkg::SFP_ANSWER;
          next_st.pready = 1'b1;
          next_st.pslverr = !(hit_ctrl || hit_ptr || hit_out || hit_dbg || hit_txin);
          next_st.prdata = '0;
          if (!pwrite) begin
            if (hit_ctrl) begin
              next_st.prdata[sfp_pkg::CONTROL_INFO_MODE_SELECT_W-1:0] = st.control_info_mode_select;
            end else if (hit_ptr) begin
              next_st.prdata = ptr_word; // RQ4
            end else if (hit_out || hit_dbg) begin
              next_st.prdata = view_word; // RQ1
            end
          end
        end
      end
      sfp_pkg::SFP_ANSWER: begin
        next_st.phase = sfp_pkg::SFP_IDLE;
      end
    endcase
    // only the mode register and the entry words take writes; pointer, port, debug ignore them
    if (done && pwrite && hit_ctrl && pstrb[0]) begin // RQ4 RQ13
      next_st.control_info_mode_select = pwdata[sfp_pkg::CONTROL_INFO_MODE_SELECT_W-1:0];
    end
    // transmit holding stage
    if (tx_out_ready) begin
      next_st.tx_valid = tx_out_valid; // RQ3
      if (tx_out_valid) begin
        next_st.tx_data = tx_out[sfp_pkg::WORD_W-1:0];
        next_st.tx_ctrl = tx_out[sfp_pkg::WORD_W +: sfp_pkg::TCI_W];
      end
    end
    // receive ready exactly tracks room after this cycle
    next_st.rx_ready = rx_next_level != FULL;
    // two channels share one set of request lines
    next_st.srq = ch0_srq | ch1_srq; // RQ10
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.control_info_mode_select <= sfp_pkg::CONTROL_INFO_MODE_SELECT_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign tx_valid = st.tx_valid;
  assign tx_data = st.tx_data;
  assign tx_ctrl = st.tx_ctrl;
  assign rx_ready = st.rx_ready;
  assign service_request_lines = st.srq;

  // ==========================================================
  // checks
  // ==========================================================
  a_dbg_no_release: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (done && !pwrite && hit_dbg) |=> rx_rd_idx == $past(rx_rd_idx))
    else $error("debug read moved the receive read pointer");
  a_out_release: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    (done && !pwrite && hit_out && rx_out_valid) |=> rx_rd_idx != $past(rx_rd_idx))
    else $error("port read did not release the entry");
  // word was latched one edge before the answer; a push into an empty fifo
  // in between must not count as a mismatch
  a_dbg_fields: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (st.pready && !pwrite && hit_dbg && $past(rx_out_valid)) |->
      st.prdata[20:16] == sfp_pkg::rci_format(st.control_info_mode_select, rx_out[20:16], rx_out[24:21])
      && st.prdata[15:0] == rx_out[15:0])
    else $error("debug view differs from oldest word");
  a_dbg_reserved: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (st.pready && !pwrite && (hit_dbg || hit_out)) |-> st.prdata[31:21] == '0)
    else $error("debug view reserved bits set");
  a_ptr_write_ign: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (done && pwrite && (hit_ptr || hit_dbg)) |=>
      tx_wr_idx == $past(tx_wr_idx) && rx_rd_idx == $past(rx_rd_idx) && st.control_info_mode_select == $past(st.control_info_mode_select))
    else $error("write to read only register had an effect");
  a_ptr_image: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    (st.phase == sfp_pkg::SFP_IDLE && psel && penable && !pwrite && hit_ptr) |=>
      st.prdata[13:8] == 6'($past(tx_rd_idx)) && st.prdata[29:24] == 6'($past(rx_rd_idx))
      && st.prdata[31:30] == 2'h0)
    else $error("pointer image wrong");
  a_tx_push: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (tx_in_valid && tx_in_ready) |=> tx_wr_idx != $past(tx_wr_idx))
    else $error("entry write did not advance the transmit write pointer");
  a_srq_merge: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    1'b1 |=> service_request_lines == ($past(ch0_srq) | $past(ch1_srq)))
    else $error("request lines not merged");
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    st.pready |=> !st.pready ##1 (!st.pready || $past(psel)))
    else $error("ready held more than one cycle");
  a_rx_honest: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (rx_valid && st.rx_ready) |=> rx_wr_idx != $past(rx_wr_idx))
    else $error("accepted receive word was dropped");
endmodule

/* dv/sfp_chan_model.sv */
`timescale 1ns/1ps
// ==========================================
// channel side: tx consumer and rx producer
// ==========================================
module sfp_chan_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] tx_data,
  input wire logic [4:0] tx_ctrl,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [15:0] rx_data,
  output logic [4:0] rx_stat,
  output logic [3:0] rx_len
);
  logic [20:0] tx_got[$]; // words taken, {ctrl, data}
  logic [24:0] rx_pend[$]; // words to offer, {len, stat, data}
  logic tx_stall = 1'b0; // bench holds the consumer off
  logic tv; // tx_valid seen before the edge
  logic rr; // rx_ready seen before the edge
  logic [20:0] tw; // tx word seen before the edge
  integer seed = 62;
  integer r;
  // sample design outputs away from the active edge
  always @(negedge pclk) begin
    tv = tx_valid;
    rr = rx_ready;
    tw = {tx_ctrl, tx_data};
  end
  // take tx words, offer rx words held until accepted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      {rx_len, rx_stat, rx_data} <= 25'h0;
    end else begin
      r = $random(seed);
      if (tv && tx_ready) tx_got.push_back(tw);
      if (rx_valid && rr) void'(rx_pend.pop_front());
      // prompt or slow, never while stalled
      tx_ready <= !tx_stall && (r[1:0] != 2'h0);
      if (rx_pend.size() > 0) begin
        rx_valid <= 1'b1;
        {rx_len, rx_stat, rx_data} <= rx_pend[0];
      end else begin
        // idle lines toggle, no stale word left
        rx_valid <= 1'b0;
        {rx_len, rx_stat, rx_data} <= ~{rx_len, rx_stat, rx_data};
      end
    end
  end
endmodule

/* dv/sfp_top_tb.sv */
`timescale 1ns/1ps
// ==========================================
// bench for the fifo pointer and debug view
// ==========================================
module sfp_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [15:0] tx_data, rx_data;
  logic [4:0] tx_ctrl, rx_stat, ent;
  logic [3:0] rx_len;
  logic [5:0] ch0_srq = 6'h0, ch1_srq = 6'h0, srq;
  logic [20:0] tx_exp[$]; // reference tx words {entry, data}
  logic [24:0] rx_exp[$]; // reference rx words {len, stat, data}
  logic [24:0] w;
  integer fails = 0, tests_run = 0, seed = 62, i, m, n;
  always #10 pclk = ~pclk;
  sfp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_ctrl(tx_ctrl), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_stat(rx_stat), .rx_len(rx_len), .ch0_srq(ch0_srq),
    .ch1_srq(ch1_srq), .service_request_lines(srq));
  sfp_chan_model mdl_u (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_ctrl(tx_ctrl), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_stat(rx_stat), .rx_len(rx_len));
  // ==========================================
  // helpers
  // ==========================================
  // verdict and end of run
  task end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // compare one register value
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer, answer taken at the pready edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected receive view for a mode
  function automatic logic [31:0] view(input int md, input logic [24:0] v);
    logic [4:0] c;
    case (md)
      0: c = v[20:16];
      1: c = {v[20], v[24:21]};
      2: c = {v[20:19], v[23:21]};
      default: c = {v[24], v[19:16]};
    endcase
    return {11'h0, c, v[15:0]};
  endfunction
  // ==========================================
  // tests
  // ==========================================
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and unmapped access
    apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
    chk("ptr_reset", 32'h0, rd);
    chk("ptr_err", 32'h0, {31'h0, er});
    apb(1'b0, sfp_pkg::OFF_DBG, 32'h0, 4'hF);
    chk("dbg_reset", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0, 4'hF);
    chk("unmapped_err", 32'h1, {31'h0, er});
    $display("test reset done");
    // request line merge
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      ch0_srq <= 6'($random(seed));
      ch1_srq <= 6'($random(seed));
      @(posedge pclk);
      @(negedge pclk);
      chk("srq", {26'h0, ch0_srq | ch1_srq}, {26'h0, srq});
    end
    $display("test srq done");
    // tx fill until refused with consumer stalled
    @(negedge pclk);
    mdl_u.tx_stall = 1'b1;
    apb(1'b1, sfp_pkg::OFF_TXIN, 32'h1234, 4'hE);
    for (i = 0; i < 22; i++) begin
      if (i == 20) begin
        // drain, then two more words
        apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
        chk("ptr_full", 32'h0000_0101, rd);
        apb(1'b1, sfp_pkg::OFF_PTR, 32'hFFFF_FFFF, 4'hF);
        apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
        chk("ptr_wr", 32'h0000_0101, rd);
        @(negedge pclk);
        mdl_u.tx_stall = 1'b0;
      end
      w = 25'($random(seed));
      ent = w[20:16];
      apb(1'b1, sfp_pkg::OFF_TXIN + {5'h0, ent, 2'h0}, {16'h0, w[15:0]}, 4'hF);
      if (i < 17 || i >= 20) tx_exp.push_back({ent, w[15:0]});
    end
    n = 0;
    while (mdl_u.tx_got.size() < 19 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 400) fails++;
    for (i = 0; i < 19; i++) chk("tx_word", {11'h0, tx_exp[i]}, {11'h0, mdl_u.tx_got[i]});
    apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
    chk("ptr_tx", 32'h0000_0303, rd);
    $display("test tx done");
    // rx fill until refused, no reads meanwhile
    @(negedge pclk);
    for (i = 0; i < 18; i++) begin
      w = 25'($random(seed));
      rx_exp.push_back(w);
      mdl_u.rx_pend.push_back(w);
    end
    n = 0;
    while (mdl_u.rx_pend.size() > 2 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 400) fails++;
    apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
    chk("ptr_rxfull", 32'h0000_0303, rd);
    for (m = 0; m < 4; m++) begin
      apb(1'b1, sfp_pkg::OFF_CTRL, m, 4'hF);
      apb(1'b0, sfp_pkg::OFF_DBG, 32'h0, 4'hF);
      chk("dbg_mode", view(m, rx_exp[0]), rd);
    end
    apb(1'b1, sfp_pkg::OFF_DBG, 32'h001F_FFFF, 4'hF);
    apb(1'b0, sfp_pkg::OFF_DBG, 32'h0, 4'hF);
    chk("dbg_wr", view(3, rx_exp[0]), rd);
    apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
    chk("ptr_dbg", 32'h0000_0303, rd);
    // drain through the port, debug view first each time
    for (i = 0; i < 18; i++) begin
      m = $random(seed) & 3;
      apb(1'b1, sfp_pkg::OFF_CTRL, m, 4'hF);
      apb(1'b0, sfp_pkg::OFF_DBG, 32'h0, 4'hF);
      chk("dbg_word", view(m, rx_exp[0]), rd);
      apb(1'b0, sfp_pkg::OFF_OUT, 32'h0, 4'hF);
      chk("port_word", view(m, rx_exp.pop_front()), rd);
    end
    apb(1'b0, sfp_pkg::OFF_OUT, 32'h0, 4'hF);
    chk("port_empty", 32'h0, rd);
    apb(1'b0, sfp_pkg::OFF_PTR, 32'h0, 4'hF);
    chk("ptr_rx", 32'h0202_0303, rd);
    $display("test rx done");
    end_of_test;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_of_test;
  end
endmodule
